// [inc/brdec_pkg.sv]
package brdec_pkg;
   // opcodes
   localparam logic [7:0] OP_JMP_IND   = 8'h73;
   localparam logic [7:0] OP_SJMP      = 8'h80;
   localparam logic [7:0] OP_JZ        = 8'h60;
   localparam logic [7:0] OP_JNZ       = 8'h70;
   localparam logic [7:0] OP_JC        = 8'h40;
   localparam logic [7:0] OP_JNC       = 8'h50;
   localparam logic [7:0] OP_JB        = 8'h20;
   localparam logic [7:0] OP_JNB       = 8'h30;
   localparam logic [7:0] OP_JBC       = 8'h10;
   localparam logic [7:0] OP_CJ_DIR    = 8'hb5;
   localparam logic [7:0] OP_CJ_IMM    = 8'hb4;
   localparam logic [7:0] OP_CJ_REG    = 8'hb8; // b8..bf, low 3 bits select register
   localparam logic [7:0] OP_CJ_IND    = 8'hb6; // b6..b7
   localparam logic [7:0] OP_DJ_REG    = 8'hd8; // d8..df
   localparam logic [7:0] OP_DJ_DIR    = 8'hd5;
   localparam logic [7:0] OP_ANL_C     = 8'h82;
   localparam logic [7:0] OP_ANL_NC    = 8'hb0;
   localparam logic [7:0] OP_ORL_C     = 8'h72;
   localparam logic [7:0] OP_ORL_NC    = 8'ha0;
   localparam logic [7:0] OP_MOV_CB    = 8'ha2;
   localparam logic [7:0] OP_MOV_BC    = 8'h92;
   // cycle counts
   localparam logic [3:0] CYC_2        = 4'h2;
   localparam logic [3:0] CYC_3        = 4'h3;
   localparam logic [3:0] CYC_4        = 4'h4;
   localparam logic [3:0] CYC_5        = 4'h5;
   localparam logic [3:0] CYC_6        = 4'h6;
   // after reset
   localparam logic [15:0] PC_RESET    = 16'h0000;
   localparam logic        CARRY_RESET = 1'b0;
   // condition kinds
   typedef enum logic [3:0] {
      COND_ALWAYS = 4'h0,
      COND_ACC_Z  = 4'h1,
      COND_ACC_NZ = 4'h2,
      COND_C      = 4'h3,
      COND_NC     = 4'h4,
      COND_BIT    = 4'h5,
      COND_NBIT   = 4'h6,
      COND_NE     = 4'h7,
      COND_DEC_NZ = 4'h8,
      COND_NONE   = 4'h9
   } cond_t;
   // carry operations
   typedef enum logic [2:0] {
      COP_NONE = 3'h0,
      COP_AND  = 3'h1,
      COP_ANDN = 3'h2,
      COP_OR   = 3'h3,
      COP_ORN  = 3'h4,
      COP_MOV  = 3'h5
   } carry_op_t;
endpackage

// [hw/op_table.sv]
`timescale 1ns/100ps
// combinational opcode table: length, cycles, condition, carry op
module op_table
(
   input  wire logic [7:0]              i_opcode,
   output logic                         o_known,
   output logic [1:0]                   o_len,
   output logic [3:0]                   o_cyc_nt,
   output logic [3:0]                   o_cyc_tk,
   output brdec_pkg::cond_t             o_cond,
   output brdec_pkg::carry_op_t         o_cop,
   output logic                         o_indirect,
   output logic                         o_bit_clr,
   output logic                         o_bit_wr
);
   // decode one opcode
   always_comb
   begin
      o_known    = 1'b1;
      o_len      = 2'd2;
      o_cyc_nt   = brdec_pkg::CYC_2;
      o_cyc_tk   = brdec_pkg::CYC_2;
      o_cond     = brdec_pkg::COND_NONE;
      o_cop      = brdec_pkg::COP_NONE;
      o_indirect = 1'b0;
      o_bit_clr  = 1'b0;
      o_bit_wr   = 1'b0;
      if (i_opcode[7:3] == brdec_pkg::OP_CJ_REG[7:3])
      begin
         o_len = 2'd3; o_cyc_nt = brdec_pkg::CYC_4; o_cyc_tk = brdec_pkg::CYC_6;
         o_cond = brdec_pkg::COND_NE;
      end
      else if (i_opcode[7:3] == brdec_pkg::OP_DJ_REG[7:3])
      begin
         o_len = 2'd2; o_cyc_nt = brdec_pkg::CYC_3; o_cyc_tk = brdec_pkg::CYC_5;
         o_cond = brdec_pkg::COND_DEC_NZ;
      end
      else if (i_opcode[7:1] == brdec_pkg::OP_CJ_IND[7:1])
      begin
         o_len = 2'd3; o_cyc_nt = brdec_pkg::CYC_4; o_cyc_tk = brdec_pkg::CYC_6;
         o_cond = brdec_pkg::COND_NE;
      end
      else
      begin
         case (i_opcode)
            brdec_pkg::OP_JMP_IND:
            begin
               o_len = 2'd1; o_cyc_nt = brdec_pkg::CYC_6; o_cyc_tk = brdec_pkg::CYC_6;
               o_cond = brdec_pkg::COND_ALWAYS; o_indirect = 1'b1;
            end
            brdec_pkg::OP_SJMP:
            begin
               o_cyc_nt = brdec_pkg::CYC_4; o_cyc_tk = brdec_pkg::CYC_4;
               o_cond = brdec_pkg::COND_ALWAYS;
            end
            brdec_pkg::OP_JZ:
            begin
               o_cyc_nt = brdec_pkg::CYC_3; o_cyc_tk = brdec_pkg::CYC_5;
               o_cond = brdec_pkg::COND_ACC_Z;
            end
            brdec_pkg::OP_JNZ:
            begin
               o_cyc_nt = brdec_pkg::CYC_3; o_cyc_tk = brdec_pkg::CYC_5;
               o_cond = brdec_pkg::COND_ACC_NZ;
            end
            brdec_pkg::OP_JC:
            begin
               o_cyc_tk = brdec_pkg::CYC_4; o_cond = brdec_pkg::COND_C;
            end
            brdec_pkg::OP_JNC:
            begin
               o_cyc_tk = brdec_pkg::CYC_4; o_cond = brdec_pkg::COND_NC;
            end
            brdec_pkg::OP_JB, brdec_pkg::OP_JNB, brdec_pkg::OP_JBC:
            begin
               o_len = 2'd3; o_cyc_nt = brdec_pkg::CYC_4; o_cyc_tk = brdec_pkg::CYC_6;
               o_cond = (i_opcode == brdec_pkg::OP_JNB) ? brdec_pkg::COND_NBIT
                                                        : brdec_pkg::COND_BIT;
               o_bit_clr = (i_opcode == brdec_pkg::OP_JBC);
            end
            brdec_pkg::OP_CJ_DIR, brdec_pkg::OP_CJ_IMM:
            begin
               o_len = 2'd3; o_cyc_nt = brdec_pkg::CYC_4; o_cyc_tk = brdec_pkg::CYC_6;
               o_cond = brdec_pkg::COND_NE;
            end
            brdec_pkg::OP_DJ_DIR:
            begin
               o_len = 2'd3; o_cyc_nt = brdec_pkg::CYC_4; o_cyc_tk = brdec_pkg::CYC_6;
               o_cond = brdec_pkg::COND_DEC_NZ;
            end
            brdec_pkg::OP_ANL_C:  o_cop = brdec_pkg::COP_AND;
            brdec_pkg::OP_ANL_NC: o_cop = brdec_pkg::COP_ANDN;
            brdec_pkg::OP_ORL_C:  o_cop = brdec_pkg::COP_OR;
            brdec_pkg::OP_ORL_NC: o_cop = brdec_pkg::COP_ORN;
            brdec_pkg::OP_MOV_CB: o_cop = brdec_pkg::COP_MOV;
            brdec_pkg::OP_MOV_BC:
            begin
               o_cyc_nt = brdec_pkg::CYC_3; o_cyc_tk = brdec_pkg::CYC_3;
               o_bit_wr = 1'b1;
            end
            default:  o_known = 1'b0;
         endcase
      end
   end
endmodule

// [hw/operand_cmp.sv]
`timescale 1ns/100ps
// branch condition evaluation for a decoded opcode
module operand_cmp
(
   input  wire brdec_pkg::cond_t i_cond,
   input  wire logic [7:0]       i_acc,
   input  wire logic             i_carry,
   input  wire logic             i_bit,
   input  wire logic [7:0]       i_lhs,
   input  wire logic [7:0]       i_rhs,
   output logic                  o_taken,
   output logic [7:0]            o_dec
);
   // decremented operand used by the decrement-and-branch forms
   assign o_dec = i_lhs - 8'h01;

   // pick the condition
   always_comb
   begin
      case (i_cond)
         brdec_pkg::COND_ALWAYS: o_taken = 1'b1;
         brdec_pkg::COND_ACC_Z:  o_taken = (i_acc == 8'h00);
         brdec_pkg::COND_ACC_NZ: o_taken = (i_acc != 8'h00);
         brdec_pkg::COND_C:      o_taken = i_carry;
         brdec_pkg::COND_NC:     o_taken = ~i_carry;
         brdec_pkg::COND_BIT:    o_taken = i_bit;
         brdec_pkg::COND_NBIT:   o_taken = ~i_bit;
         brdec_pkg::COND_NE:     o_taken = (i_lhs != i_rhs);
         brdec_pkg::COND_DEC_NZ: o_taken = (o_dec != 8'h00);
         default:                o_taken = 1'b0;
      endcase
   end
endmodule

// [hw/branch_and_bit_op_decode.sv]
`timescale 1ns/100ps
// What this block does
// - 0x73 jumps to data_pointer plus A, 6 cycles
// - 0x80 short jump, two bytes, 4 cycles
// - 0x60 branch if A zero, 3/5
// - 0x70 branch if A nonzero, 3/5
// - 0x40 branch if carry set, 2/4
// - 0x50 branch if carry clear, 2/4
// - 0x20 branch if bit one, 4/6
// - 0x30 branch if bit zero, 4/6
// - 0x10 branch if bit one, clears it
// - 0xB5 compare direct with A, 4/6
// - 0xB4 compare immediate with A, 4/6
// - 0xB8-0xBF compare immediate with register, 4/6
// - 0xB6-0xB7 compare immediate with indirect, 4/6
// - 0xD8-0xDF decrement register, branch nonzero, 3/5
// - 0xD5 decrement direct, branch nonzero, 4/6
// - 0x82 carry gets carry AND bit
// - 0xB0 carry gets carry AND NOT bit
// - 0x72 carry gets carry OR bit
// - 0xA0 carry gets carry OR NOT bit
// - 0xA2 carry gets bit, 2 cycles
// - 0x92 bit gets carry, 3 cycles
module branch_and_bit_op_decode
(
   input  wire logic        i_core_clk,
   input  wire logic        i_rstn,
   input  wire logic        i_start,
   input  wire logic [7:0]  i_opcode,
   input  wire logic [7:0]  i_byte1,
   input  wire logic [7:0]  i_byte2,
   input  wire logic [7:0]  i_acc,
   input  wire logic [15:0] i_data_pointer,
   input  wire logic        i_bit,
   input  wire logic [7:0]  i_operand,
   input  wire logic [15:0] i_pc,
   output logic             o_busy,
   output logic             o_done,
   output logic             o_known,
   output logic             o_taken,
   output logic [15:0]      o_next_pc,
   output logic             o_carry,
   output logic             o_bit_we,
   output logic             o_bit_val,
   output logic             o_byte_we,
   output logic [7:0]       o_byte_val
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_EXEC = 2'b10
   } state_t;

   state_t               state;
   logic [3:0]           count;
   logic                 t_known;
   logic [1:0]           t_len;
   logic [3:0]           t_cyc_nt;
   logic [3:0]           t_cyc_tk;
   brdec_pkg::cond_t     t_cond;
   brdec_pkg::carry_op_t t_cop;
   logic                 t_indirect;
   logic                 t_bit_clr;
   logic                 t_bit_wr;
   logic                 c_taken;
   logic [7:0]           c_dec;
   logic [7:0]           cmp_rhs;
   logic                 is_cjne;
   logic                 is_djnz;
   logic [15:0]          seq_pc;
   logic [15:0]          rel_pc;
   logic [7:0]           rel;
   logic                 next_carry;
   logic [15:0]          next_pc;
   logic [3:0]           next_count;

   op_table u_table
   (
      .i_opcode   (i_opcode),
      .o_known    (t_known),
      .o_len      (t_len),
      .o_cyc_nt   (t_cyc_nt),
      .o_cyc_tk   (t_cyc_tk),
      .o_cond     (t_cond),
      .o_cop      (t_cop),
      .o_indirect (t_indirect),
      .o_bit_clr  (t_bit_clr),
      .o_bit_wr   (t_bit_wr)
   );

   // compare forms use the immediate byte as second operand except the two compare-with-A forms (0xB5, 0xB4)
   assign is_cjne = (t_cond == brdec_pkg::COND_NE);
   assign is_djnz = (t_cond == brdec_pkg::COND_DEC_NZ);
   assign cmp_rhs = (i_opcode == brdec_pkg::OP_CJ_DIR || i_opcode == brdec_pkg::OP_CJ_IMM)
                    ? i_acc : i_byte1;

   operand_cmp u_cmp
   (
      .i_cond  (t_cond),
      .i_acc   (i_acc),
      .i_carry (o_carry),
      .i_bit   (i_bit),
      .i_lhs   ((i_opcode == brdec_pkg::OP_CJ_IMM) ? i_byte1 : i_operand),
      .i_rhs   (cmp_rhs),
      .o_taken (c_taken),
      .o_dec   (c_dec)
   );

   // relative offset is the last instruction byte
   assign rel    = (t_len == 2'd3) ? i_byte2 : i_byte1;
   assign seq_pc = i_pc + {14'h0000, t_len};
   assign rel_pc = seq_pc + {{8{rel[7]}}, rel};

   // target selection
   always_comb
   begin
      if (t_indirect)
         next_pc = i_data_pointer + {8'h00, i_acc};
      else if (c_taken && t_cond != brdec_pkg::COND_NONE)
         next_pc = rel_pc;
      else
         next_pc = seq_pc;
   end

   // carry update for the boolean group
   always_comb
   begin
      case (t_cop)
         brdec_pkg::COP_AND:  next_carry = o_carry & i_bit;
         brdec_pkg::COP_ANDN: next_carry = o_carry & ~i_bit;
         brdec_pkg::COP_OR:   next_carry = o_carry | i_bit;
         brdec_pkg::COP_ORN:  next_carry = o_carry | ~i_bit;
         brdec_pkg::COP_MOV:  next_carry = i_bit;
         default:             next_carry = o_carry;
      endcase
   end

   // duration of the instruction, counting the accept cycle
   assign next_count = (c_taken ? t_cyc_tk : t_cyc_nt) - 4'h1;

   // sequencer: accept in idle, hold busy for the remaining cycles
   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         state  <= ST_IDLE;
         count  <= 4'h0;
         o_busy <= 1'b0;
         o_done <= 1'b0;
      end
      else
      begin
         o_done <= 1'b0;
         case (state)
            ST_IDLE:
            begin
               if (i_start && t_known)
               begin
                  state  <= ST_EXEC;
                  count  <= next_count;
                  o_busy <= 1'b1;
               end
            end
            ST_EXEC:
            begin
               if (count == 4'h1)
               begin
                  state  <= ST_IDLE;
                  o_busy <= 1'b0;
                  o_done <= 1'b1;
               end
               count <= count - 4'h1;
            end
            default:
            begin
               state  <= ST_IDLE;
               o_busy <= 1'b0;
            end
         endcase
      end
   end

   // results latched at accept
   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_known    <= 1'b0;
         o_taken    <= 1'b0;
         o_next_pc  <= brdec_pkg::PC_RESET;
         o_carry    <= brdec_pkg::CARRY_RESET;
         o_bit_we   <= 1'b0;
         o_bit_val  <= 1'b0;
         o_byte_we  <= 1'b0;
         o_byte_val <= 8'h00;
      end
      else
      begin
         o_bit_we  <= 1'b0;
         o_byte_we <= 1'b0;
         if (state == ST_IDLE && i_start)
         begin
            o_known <= t_known;
            if (t_known)
            begin
               o_taken   <= c_taken && t_cond != brdec_pkg::COND_NONE;
               o_next_pc <= next_pc;
               o_carry   <= next_carry;
               if (t_bit_wr)
               begin
                  o_bit_we  <= 1'b1;
                  o_bit_val <= o_carry;
               end
               else if (t_bit_clr && i_bit)
               begin
                  o_bit_we  <= 1'b1;
                  o_bit_val <= 1'b0;
               end
               if (is_djnz)
               begin
                  o_byte_we  <= 1'b1;
                  o_byte_val <= c_dec;
               end
            end
         end
      end
   end

   // checks
   logic        acc_evt;
   logic [3:0]  acc_len;
   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         acc_evt <= 1'b0;
         acc_len <= 4'h0;
      end
      else
      begin
         acc_evt <= state == ST_IDLE && i_start && t_known;
         if (state == ST_IDLE && i_start && t_known)
            acc_len <= 4'h1;
         else if (o_busy)
            acc_len <= acc_len + 4'h1;
      end
   end

   a_sjmp_len: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      state == ST_IDLE && i_start && i_opcode == brdec_pkg::OP_SJMP |=> o_busy [*3] ##1 !o_busy)
      else $error("short jump length wrong");
   a_jmp_ind: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      state == ST_IDLE && i_start && i_opcode == brdec_pkg::OP_JMP_IND
      |=> o_next_pc == $past(i_data_pointer) + {8'h00, $past(i_acc)} ##5 o_done)
      else $error("indirect jump wrong");
   a_jz_ntk: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      state == ST_IDLE && i_start && i_opcode == brdec_pkg::OP_JZ && i_acc != 8'h00
      |=> !o_taken ##2 o_done)
      else $error("jz not-taken timing wrong");
   a_jc_tk: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      state == ST_IDLE && i_start && i_opcode == brdec_pkg::OP_JC && o_carry
      |=> o_taken ##3 o_done)
      else $error("jc taken timing wrong");
   a_jnc_ntk: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      state == ST_IDLE && i_start && i_opcode == brdec_pkg::OP_JNC && o_carry
      |=> !o_taken && o_next_pc == $past(i_pc) + 16'h0002 ##1 o_done)
      else $error("jnc not-taken wrong");
   a_jbc_clear: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      state == ST_IDLE && i_start && i_opcode == brdec_pkg::OP_JBC && i_bit
      |=> o_bit_we && !o_bit_val && o_taken)
      else $error("bit not cleared");
   a_anl_c: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      state == ST_IDLE && i_start && i_opcode == brdec_pkg::OP_ANL_C
      |=> o_carry == ($past(o_carry) & $past(i_bit)) ##1 o_done)
      else $error("carry and wrong");
   a_mov_bc: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      state == ST_IDLE && i_start && i_opcode == brdec_pkg::OP_MOV_BC
      |=> o_bit_we && o_bit_val == $past(o_carry) ##2 o_done)
      else $error("bit store wrong");
   a_done_len: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      o_done |-> acc_len >= brdec_pkg::CYC_2 && acc_len <= brdec_pkg::CYC_6)
      else $error("busy span out of range");

   c_taken_br: cover property (@(posedge i_core_clk) o_done && o_taken);
   c_not_taken: cover property (@(posedge i_core_clk) o_done && !o_taken);
   c_djnz: cover property (@(posedge i_core_clk) o_byte_we);
   c_b2b: cover property (@(posedge i_core_clk) acc_evt ##1 !o_busy ##1 acc_evt);
endmodule

// [sim/prog_mem.sv]
`timescale 1ns/100ps
// program memory model: hands out three instruction bytes at the fetch address
module prog_mem
(
   input  wire logic        i_core_clk,
   input  wire logic        i_wr,
   input  wire logic [15:0] i_waddr,
   input  wire logic [23:0] i_wdata,
   input  wire logic        i_rd,
   input  wire logic [15:0] i_addr,
   output logic [7:0]       o_b0,
   output logic [7:0]       o_b1,
   output logic [7:0]       o_b2
);
   logic [7:0]  mem [0:4095];
   logic [7:0]  junk = 8'h3c;
   logic [11:0] a;
   // a whole instruction lands in one write; idle bytes keep moving
   always @(posedge i_core_clk)
   begin
      if (i_wr)
      begin
         mem[i_waddr[11:0]] <= i_wdata[7:0];
         mem[i_waddr[11:0] + 12'h001] <= i_wdata[15:8];
         mem[i_waddr[11:0] + 12'h002] <= i_wdata[23:16];
      end
      junk <= ~junk + 8'h5b;
   end
   // a bus not being read shows a changing pattern, never stale bytes
   assign a = i_addr[11:0];
   assign o_b0 = i_rd ? mem[a] : junk;
   assign o_b1 = i_rd ? mem[a + 12'h001] : ~junk;
   assign o_b2 = i_rd ? mem[a + 12'h002] : junk ^ 8'ha5;
endmodule

// [sim/test_branch_and_bit_op_decode.sv]
`timescale 1ns/100ps
// sweeps every opcode through the decoder, fetched from a program memory model
module test_branch_and_bit_op_decode;
   logic        i_core_clk = 1'b0;
   logic        i_rstn = 1'b0;
   logic        i_start = 1'b0;
   logic        i_rd = 1'b0;
   logic        i_wr = 1'b0;
   logic [15:0] i_waddr = 16'h0000;
   logic [23:0] i_wdata = 24'h000000;
   logic [7:0]  i_opcode, i_byte1, i_byte2;
   logic [7:0]  i_acc = 8'h00;
   logic [15:0] i_data_pointer = 16'h0000;
   logic        i_bit = 1'b0;
   logic [7:0]  i_operand = 8'h00;
   logic [15:0] i_pc = 16'h0000;
   logic        o_busy, o_done, o_known, o_taken, o_carry;
   logic        o_bit_we, o_bit_val, o_byte_we;
   logic [15:0] o_next_pc;
   logic [7:0]  o_byte_val;
   logic [7:0]  ops[$], b1s[$], b2s[$];
   logic [33:0] notes[$];
   logic [31:0] r;
   logic        cm = 1'b0;
   logic        sb = 1'b0, sbv = 1'b0, sy = 1'b0;
   logic [7:0]  syv = 8'h00;
   logic [3:0]  busy_n = 4'h0;
   int          fails = 0, check_count = 0, cyc = 0;

   always #12.5 i_core_clk = ~i_core_clk;

   prog_mem mem (.i_core_clk(i_core_clk), .i_wr(i_wr), .i_waddr(i_waddr), .i_wdata(i_wdata),
                 .i_rd(i_rd), .i_addr(i_pc), .o_b0(i_opcode), .o_b1(i_byte1), .o_b2(i_byte2));

   branch_and_bit_op_decode dut (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_start(i_start),
      .i_opcode(i_opcode), .i_byte1(i_byte1), .i_byte2(i_byte2), .i_acc(i_acc),
      .i_data_pointer(i_data_pointer), .i_bit(i_bit), .i_operand(i_operand), .i_pc(i_pc),
      .o_busy(o_busy), .o_done(o_done), .o_known(o_known), .o_taken(o_taken),
      .o_next_pc(o_next_pc), .o_carry(o_carry), .o_bit_we(o_bit_we), .o_bit_val(o_bit_val),
      .o_byte_we(o_byte_we), .o_byte_val(o_byte_val));

   // instruction length in bytes, zero for opcodes outside this block
   function automatic logic [3:0] blen(input logic [7:0] op);
      if (op == 8'h73) return 4'h1;
      if (op inside {8'h80, 8'h60, 8'h70, 8'h40, 8'h50, 8'h82, 8'hb0, 8'h72, 8'ha0, 8'ha2,
                     8'h92, [8'hd8:8'hdf]}) return 4'h2;
      if (op inside {8'h20, 8'h30, 8'h10, 8'hb5, 8'hb4, 8'hd5, [8'hb6:8'hbf]}) return 4'h3;
      return 4'h0;
   endfunction

   function automatic logic [15:0] pc_of(input int k);
      return 16'hff00 + {k[13:0], 2'b00};
   endfunction

   task automatic check(input string what, input logic [33:0] exp, input logic [33:0] got);
      check_count++;
      if (exp !== got)
      begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // place one instruction in program memory
   task automatic add_op(input logic [7:0] op);
      ops.push_back(op);
      b1s.push_back($urandom);
      b2s.push_back($urandom);
      @(negedge i_core_clk);
      i_wr = 1'b1;
      i_waddr = pc_of(ops.size() - 1);
      i_wdata = {b2s[$], b1s[$], op};
   endtask

   // run instruction k, note the expected outcome, return at the done cycle
   task automatic exec(input int k);
      logic [7:0]  op, b1, rel, dec, acc, opnd;
      logic [15:0] pc, tg, dp;
      logic [3:0]  len, cn, ct;
      logic        tk, bv, c, bwe, bval, ywe;
      int          w;
      op = ops[k];
      b1 = b1s[k];
      r = $urandom;
      dp = r[31:16];
      acc = r[1] ? 8'h00 : r[15:8];
      if (op == 8'hb4 && r[0]) acc = b1;
      opnd = r[23:16];
      if (r[0])
         case (op) inside
            8'hb5: opnd = acc;
            [8'hb6:8'hbf]: opnd = b1;
            8'hd5, [8'hd8:8'hdf]: opnd = 8'h01;
         endcase
      bv = r[2];
      dec = opnd - 8'h01;
      len = blen(op);
      pc = pc_of(k);
      rel = (len == 4'h3) ? b2s[k] : b1;
      tg = pc + {12'h000, len} + {{8{rel[7]}}, rel};
      {tk, c, bwe, bval, ywe, cn, ct} = {1'b0, cm, 3'b000, 4'h2, 4'h2};
      case (op) inside
         8'h73: {tk, cn, ct, tg} = {1'b1, 4'h6, 4'h6, dp + {8'h00, acc}};
         8'h80: {tk, cn, ct} = {1'b1, 4'h4, 4'h4};
         8'h60: {tk, cn, ct} = {acc == 8'h00, 4'h3, 4'h5};
         8'h70: {tk, cn, ct} = {acc != 8'h00, 4'h3, 4'h5};
         8'h40: {tk, cn, ct} = {cm, 4'h2, 4'h4};
         8'h50: {tk, cn, ct} = {~cm, 4'h2, 4'h4};
         8'h20: {tk, cn, ct} = {bv, 4'h4, 4'h6};
         8'h30: {tk, cn, ct} = {~bv, 4'h4, 4'h6};
         8'h10: {tk, bwe, cn, ct} = {bv, bv, 4'h4, 4'h6};
         8'hb5: {tk, cn, ct} = {opnd != acc, 4'h4, 4'h6};
         8'hb4: {tk, cn, ct} = {b1 != acc, 4'h4, 4'h6};
         [8'hb6:8'hbf]: {tk, cn, ct} = {opnd != b1, 4'h4, 4'h6};
         [8'hd8:8'hdf]: {tk, ywe, cn, ct} = {dec != 8'h00, 1'b1, 4'h3, 4'h5};
         8'hd5: {tk, ywe, cn, ct} = {dec != 8'h00, 1'b1, 4'h4, 4'h6};
         8'h82: c = cm & bv;
         8'hb0: c = cm & ~bv;
         8'h72: c = cm | bv;
         8'ha0: c = cm | ~bv;
         8'ha2: c = bv;
         8'h92: {bwe, bval, cn} = {1'b1, cm, 4'h3};
      endcase
      i_pc = pc;
      i_rd = 1'b1;
      i_start = 1'b1;
      i_acc = acc;
      i_data_pointer = dp;
      i_bit = bv;
      i_operand = opnd;
      if (len == 4'h0)
      begin
         @(negedge i_core_clk);
         check("unknown", 34'h0, {32'h0, o_known, o_busy});
         return;
      end
      notes.push_back({tk ? tg : pc + {12'h000, len}, tk, c, tk ? ct : cn, bwe, bval,
                       ywe, ywe ? dec : 8'h00, 1'b1});
      cm = c;
      for (w = 0; w < 20; w++)
      begin
         @(negedge i_core_clk);
         if (o_done === 1'b1) break;
         // half the time keep a garbage request up while busy: it must be ignored
         if (r[3]) i_rd = 1'b0;
         else i_start = 1'b0;
      end
      if (w == 20)
      begin
         fails++;
         $display("MISMATCH done expected 1 seen 0");
      end
   endtask

   // watch the outputs and compare each finished instruction with the oldest note
   always @(negedge i_core_clk)
   begin
      if (o_busy === 1'b1) busy_n = busy_n + 4'h1;
      if (o_bit_we === 1'b1) {sb, sbv} = {1'b1, o_bit_val};
      if (o_byte_we === 1'b1) {sy, syv} = {1'b1, o_byte_val};
      if (o_done === 1'b1)
      begin
         if (notes.size() == 0)
            check("unexpected done", 34'h0, 34'h1);
         else
            check("result", notes.pop_front(), {o_next_pc, o_taken, o_carry, busy_n + 4'h1,
                  sb, sbv, sy, syv, o_known});
         {busy_n, sb, sbv, sy, syv} = 15'h0000;
      end
   end

   // cut a hang short
   always @(posedge i_core_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         wrap_up();
      end
   end

   // main sequence
   initial
   begin
      r = $urandom(32'h81bb);
      repeat (20) @(negedge i_core_clk);
      i_rstn = 1'b1;
      for (int op = 0; op < 256; op++)
         for (int k = 0; k < ((blen(op[7:0]) != 4'h0) ? 4 : 1); k++)
         begin
            if (blen(op[7:0]) != 4'h0) add_op(8'ha2);
            add_op(op[7:0]);
         end
      @(negedge i_core_clk);
      i_wr = 1'b0;
      $display("test load done");
      for (int k = 0; k < ops.size(); k++) exec(k);
      i_start = 1'b0;
      repeat (4) @(negedge i_core_clk);
      check("pending notes", 34'h0, 34'(notes.size()));
      $display("test sweep done");
      i_rstn = 1'b0;
      @(negedge i_core_clk);
      check("reset", 34'h0, {o_next_pc, o_carry, o_busy, o_done, o_taken, o_known});
      i_rstn = 1'b1;
      // first request right at the first edge after release, carry back at zero
      cm = 1'b0;
      exec(17);
      i_start = 1'b0;
      @(negedge i_core_clk);
      $display("test reset done");
      wrap_up();
   end
endmodule
